// file: include/scp_regs.svh
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
// Byte address of the refresh/clock control word
`define SCP_CTRL_ADDR          8'h1c
// Field positions inside the control word
`define SCP_ROM_CKE_BIT        16
`define SCP_ROM_RUN_BIT        17
`define SCP_CKE1_BIT           20
`define SCP_CLK1_RUN_BIT       21
`define SCP_CLK1_HALF_BIT      22
`define SCP_CLK2_RUN_BIT       25
`define SCP_CLK2_HALF_BIT      26
`define SCP_CKE_APD_BIT        28
`define SCP_CLK_APD_BIT        29
`define SCP_SELF_REFRESH_BIT   31
// Reset values of the writable fields
`define SCP_CKE1_RST           1'b0
`define SCP_CLK_RUN_RST        1'b0
`define SCP_CLK_HALF_RST       1'b1
`define SCP_APD_RST            1'b0
`define SCP_SELF_REFRESH_RST   1'b1
// Cycles from reset release until the boot strap is caught
`define SCP_STRAP_WAIT         2'h3
`endif

// file: include/scp_pkg.sv
package scp_pkg;
  // Memory command issued by a software write to the cke bit
  typedef enum logic [1:0] {
    SCP_CMD_NONE,
    SCP_CMD_POWER_DOWN,
    SCP_CMD_PD_EXIT
  } scp_cmd_e;
  // One bus word
  typedef logic [31:0] scp_word_t;
endpackage

// file: logic/scp_clk_pin.sv
`timescale 1ns/100ps
`default_nettype none
module scp_clk_pin
  import scp_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic sync_init,
  input  wire logic run,
  input  wire logic half_rate,
  input  wire logic idle_stop,
  output logic      mem_clock_pin
);
  logic div_phase;      // Divide-by-two enable phase
  logic next_div_phase;
  logic next_pin;
  logic pin_go;         // Pin allowed to toggle

  // Divider and pin toggle; a stopped pin parks low so restart is clean
  always_comb begin
    pin_go         = run && !idle_stop;
    next_div_phase = !div_phase;
    next_pin       = mem_clock_pin;
    if (sync_init || !pin_go) begin
      next_pin       = 1'b0;   // Stopped or sleep reset
      next_div_phase = 1'b0;
    end else if (!half_rate || div_phase) begin
      next_pin = !mem_clock_pin;  // Full rate or half-rate enable
    end
  end

  // Register divider and pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_phase     <= 1'b0;
      mem_clock_pin <= 1'b0;
    end else begin
      div_phase     <= next_div_phase;
      mem_clock_pin <= next_pin;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_pin_stopped;
    !run |=> !mem_clock_pin;
  endproperty
  a_pin_stopped: assert property (p_pin_stopped)
    else $error("clock pin ran while its run control was clear");

  property p_half_rate;
    ($rose(mem_clock_pin) && $past(half_rate) && half_rate && run && !idle_stop
      && !sync_init) ##1 (half_rate && run && !idle_stop && !sync_init) |-> mem_clock_pin;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("half-rate clock pin high for only one cycle");

  property p_full_rate;
    (run && !half_rate && !idle_stop && !sync_init && mem_clock_pin)
      |=> !mem_clock_pin;
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("full-rate clock pin did not toggle");
endmodule
`default_nettype wire

// file: logic/scp_clk_power_ctrl.sv
`include "scp_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module scp_clk_power_ctrl
  import scp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // System events, same clock domain
  input  wire logic        sleep_enter,
  input  wire logic        sleep_reset,
  // Bank activity from the memory sequencer
  input  wire logic        rom_bank_busy,
  input  wire logic        sdram01_busy,
  input  wire logic        sdram23_busy,
  // Boot strap pin, asynchronous
  input  wire logic        boot_sync_rom_select,
  // Memory pins and command strobes
  output logic [2:0]       mem_clock_pin,
  output logic [1:0]       mem_clock_enable_pin,
  output logic             power_down_cmd,
  output logic             pd_exit_cmd,
  output logic             auto_cmd_enable
);
  // Control fields
  logic      sdram_cke_level;      // Cke pin 1 level control
  logic      sdram_clk1_run;       // Clock pin 1 run
  logic      sdram_clk2_run;       // Clock pin 2 run
  logic      sdram_clk1_half_rate; // Clock pin 1 divide by two
  logic      sdram_clk2_half_rate; // Clock pin 2 divide by two
  logic      cke_auto_power_down;  // Idle cke deassert enable
  logic      clk_auto_power_down;  // Idle clock stop enable
  logic      self_refresh_ctrl;    // Self-refresh control/status
  logic      rom_clk_run;          // ROM clock run
  logic      rom_cke_level;        // ROM cke level
  logic      next_sdram_cke_level;
  logic      next_sdram_clk1_run;
  logic      next_sdram_clk2_run;
  logic      next_sdram_clk1_half_rate;
  logic      next_sdram_clk2_half_rate;
  logic      next_cke_auto_power_down;
  logic      next_clk_auto_power_down;
  logic      next_self_refresh_ctrl;
  logic      next_rom_clk_run;
  logic      next_rom_cke_level;
  // Bus slave state
  logic      next_ack;
  scp_word_t next_dat;
  logic      bus_req;              // Request present and not yet answered
  logic      wr_commit;            // Write takes effect this edge
  logic      hit;                  // Address decodes to the control word
  scp_word_t ctrl_view;            // Read image of the control word
  // Strap capture
  logic      strap_meta;           // First synchroniser stage
  logic      strap_sync;           // Second stage, safe to use
  logic [1:0] strap_wait;          // Cycles since reset release
  logic [1:0] next_strap_wait;
  logic      strap_load;           // Catch strap this cycle
  // Commands
  scp_cmd_e  next_cmd;
  scp_cmd_e  cmd;
  logic      cmd_allowed;          // Clock running and not self-refreshing
  logic      sdram_busy;           // Either SDRAM pair in use

  // Byte-lane merge used for every write field
  function automatic logic lane_bit(input logic old_v, input int pos,
                                    input logic [3:0] sel, input scp_word_t d);
    lane_bit = sel[pos / 8] ? d[pos] : old_v;
  endfunction

  // Two-flop synchroniser for the strap pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end else begin
      strap_meta <= boot_sync_rom_select;
      strap_sync <= strap_meta;
    end
  end

  // Strap is caught once the synchroniser has filled after release
  always_comb begin
    next_strap_wait = strap_wait;
    if (strap_wait != `SCP_STRAP_WAIT) begin
      next_strap_wait = strap_wait + 2'h1;
    end
    strap_load = (strap_wait == 2'h2) || sleep_reset;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_wait <= 2'h0;
    end else begin
      strap_wait <= next_strap_wait;
    end
  end

  // Read image; reserved and unimplemented bits read zero
  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[`SCP_ROM_CKE_BIT]      = rom_cke_level;
    ctrl_view[`SCP_ROM_RUN_BIT]      = rom_clk_run;
    ctrl_view[`SCP_CKE1_BIT]         = sdram_cke_level;
    ctrl_view[`SCP_CLK1_RUN_BIT]     = sdram_clk1_run;
    ctrl_view[`SCP_CLK1_HALF_BIT]    = sdram_clk1_half_rate;
    ctrl_view[`SCP_CLK2_RUN_BIT]     = sdram_clk2_run;
    ctrl_view[`SCP_CLK2_HALF_BIT]    = sdram_clk2_half_rate;
    ctrl_view[`SCP_CKE_APD_BIT]      = cke_auto_power_down;
    ctrl_view[`SCP_CLK_APD_BIT]      = clk_auto_power_down;
    ctrl_view[`SCP_SELF_REFRESH_BIT] = self_refresh_ctrl;
  end

  // Bus slave: one wait state, unmapped reads give zero, writes dropped
  always_comb begin
    bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    hit       = (wb_adr_i == `SCP_CTRL_ADDR);
    wr_commit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && hit;
    next_ack  = bus_req;
    next_dat  = wb_dat_o;
    if (bus_req) begin
      next_dat = (hit && !wb_we_i) ? ctrl_view : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // Control field update: software write, then sleep, then sleep reset
  always_comb begin
    next_sdram_cke_level      = sdram_cke_level;
    next_sdram_clk1_run       = sdram_clk1_run;
    next_sdram_clk2_run       = sdram_clk2_run;
    next_sdram_clk1_half_rate = sdram_clk1_half_rate;
    next_sdram_clk2_half_rate = sdram_clk2_half_rate;
    next_cke_auto_power_down  = cke_auto_power_down;
    next_clk_auto_power_down  = clk_auto_power_down;
    next_self_refresh_ctrl    = self_refresh_ctrl;
    next_rom_clk_run          = rom_clk_run;
    next_rom_cke_level        = rom_cke_level;
    next_cmd                  = SCP_CMD_NONE;
    cmd_allowed = (sdram_clk1_run || sdram_clk2_run) && !self_refresh_ctrl;
    if (wr_commit) begin
      next_sdram_cke_level      = lane_bit(sdram_cke_level, `SCP_CKE1_BIT,
                                           wb_sel_i, wb_dat_i);
      next_sdram_clk1_run       = lane_bit(sdram_clk1_run, `SCP_CLK1_RUN_BIT,
                                           wb_sel_i, wb_dat_i);
      next_sdram_clk2_run       = lane_bit(sdram_clk2_run, `SCP_CLK2_RUN_BIT,
                                           wb_sel_i, wb_dat_i);
      next_sdram_clk1_half_rate = lane_bit(sdram_clk1_half_rate, `SCP_CLK1_HALF_BIT,
                                           wb_sel_i, wb_dat_i);
      next_sdram_clk2_half_rate = lane_bit(sdram_clk2_half_rate, `SCP_CLK2_HALF_BIT,
                                           wb_sel_i, wb_dat_i);
      // Both enables are taken as written; software keeps them equal
      next_cke_auto_power_down  = lane_bit(cke_auto_power_down, `SCP_CKE_APD_BIT,
                                           wb_sel_i, wb_dat_i);
      next_clk_auto_power_down  = lane_bit(clk_auto_power_down, `SCP_CLK_APD_BIT,
                                           wb_sel_i, wb_dat_i);
      next_self_refresh_ctrl    = lane_bit(self_refresh_ctrl, `SCP_SELF_REFRESH_BIT,
                                           wb_sel_i, wb_dat_i);
      next_rom_cke_level        = lane_bit(rom_cke_level, `SCP_ROM_CKE_BIT,
                                           wb_sel_i, wb_dat_i);
      next_rom_clk_run          = lane_bit(rom_clk_run, `SCP_ROM_RUN_BIT,
                                           wb_sel_i, wb_dat_i);
      // Command from a cke edge, judged on the state before the write
      if (cmd_allowed && sdram_cke_level && !next_sdram_cke_level) begin
        next_cmd = SCP_CMD_POWER_DOWN;
      end else if (cmd_allowed && !sdram_cke_level && next_sdram_cke_level) begin
        next_cmd = SCP_CMD_PD_EXIT;
      end
    end
    // Sleep entry wins over a write in the same cycle
    if (sleep_enter || sleep_reset) begin
      next_sdram_cke_level = `SCP_CKE1_RST;
      next_sdram_clk1_run  = `SCP_CLK_RUN_RST;
      next_sdram_clk2_run  = `SCP_CLK_RUN_RST;
      next_cmd             = SCP_CMD_NONE;
    end
    // Sleep reset restores the remaining reset values
    if (sleep_reset) begin
      next_sdram_clk1_half_rate = `SCP_CLK_HALF_RST;
      next_sdram_clk2_half_rate = `SCP_CLK_HALF_RST;
      next_cke_auto_power_down  = `SCP_APD_RST;
      next_clk_auto_power_down  = `SCP_APD_RST;
      next_self_refresh_ctrl    = `SCP_SELF_REFRESH_RST;
    end
    // Strap level copied into ROM run and cke
    if (strap_load) begin
      next_rom_clk_run   = strap_sync;
      next_rom_cke_level = strap_sync;
    end
  end

  // Register control fields; async reset loads constants only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sdram_cke_level      <= `SCP_CKE1_RST;
      sdram_clk1_run       <= `SCP_CLK_RUN_RST;
      sdram_clk2_run       <= `SCP_CLK_RUN_RST;
      sdram_clk1_half_rate <= `SCP_CLK_HALF_RST;
      sdram_clk2_half_rate <= `SCP_CLK_HALF_RST;
      cke_auto_power_down  <= `SCP_APD_RST;
      clk_auto_power_down  <= `SCP_APD_RST;
      self_refresh_ctrl    <= `SCP_SELF_REFRESH_RST;
      rom_clk_run          <= 1'b0;
      rom_cke_level        <= 1'b0;
      cmd                  <= SCP_CMD_NONE;
    end else begin
      sdram_cke_level      <= next_sdram_cke_level;
      sdram_clk1_run       <= next_sdram_clk1_run;
      sdram_clk2_run       <= next_sdram_clk2_run;
      sdram_clk1_half_rate <= next_sdram_clk1_half_rate;
      sdram_clk2_half_rate <= next_sdram_clk2_half_rate;
      cke_auto_power_down  <= next_cke_auto_power_down;
      clk_auto_power_down  <= next_clk_auto_power_down;
      self_refresh_ctrl    <= next_self_refresh_ctrl;
      rom_clk_run          <= next_rom_clk_run;
      rom_cke_level        <= next_rom_cke_level;
      cmd                  <= next_cmd;
    end
  end

  // Command strobes and the automatic-command gate
  always_comb begin
    sdram_busy     = sdram01_busy || sdram23_busy;
    power_down_cmd = (cmd == SCP_CMD_POWER_DOWN);
    pd_exit_cmd    = (cmd == SCP_CMD_PD_EXIT);
    // Sequencer may not issue MRS, read, write or refresh here
    auto_cmd_enable = sdram_cke_level && sdram_clk1_run && sdram_clk2_run;
    // With cke auto power-down set, cke pins drop while their banks sit idle
    mem_clock_enable_pin[0] = rom_cke_level && !(cke_auto_power_down && !rom_bank_busy);
    mem_clock_enable_pin[1] = sdram_cke_level && !(cke_auto_power_down && !sdram_busy);
  end

  // Clock pins: ROM pin fixed at half rate, SDRAM pins per control
  scp_clk_pin u_clk_rom (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .sync_init     (sleep_reset),
    .run           (rom_clk_run),
    .half_rate     (1'b1),
    .idle_stop     (clk_auto_power_down && !rom_bank_busy),
    .mem_clock_pin (mem_clock_pin[0])
  );

  scp_clk_pin u_clk_sd1 (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .sync_init     (sleep_reset),
    .run           (sdram_clk1_run),
    .half_rate     (sdram_clk1_half_rate),
    .idle_stop     (clk_auto_power_down && !sdram01_busy),
    .mem_clock_pin (mem_clock_pin[1])
  );

  scp_clk_pin u_clk_sd2 (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .sync_init     (sleep_reset),
    .run           (sdram_clk2_run),
    .half_rate     (sdram_clk2_half_rate),
    .idle_stop     (clk_auto_power_down && !sdram23_busy),
    .mem_clock_pin (mem_clock_pin[2])
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_strap_copy;
    strap_load |=> (rom_clk_run == $past(strap_sync)) && (rom_cke_level == $past(strap_sync));
  endproperty
  a_strap_copy: assert property (p_strap_copy)
    else $error("ROM run/cke not loaded from the boot strap");

  property p_sleep_cke;
    sleep_enter |=> !sdram_cke_level ##1 !mem_clock_enable_pin[1] || sdram_cke_level;
  endproperty
  a_sleep_cke: assert property (p_sleep_cke)
    else $error("cke bit not cleared on sleep entry");

  property p_pd_cmd;
    power_down_cmd |-> !sdram_cke_level && $past(sdram_cke_level)
      && $past(cmd_allowed) && $past(wr_commit);
  endproperty
  a_pd_cmd: assert property (p_pd_cmd)
    else $error("power-down command without a permitted cke clear");

  property p_pdx_cmd;
    (wr_commit && cmd_allowed && !sdram_cke_level && next_sdram_cke_level
      && !sleep_enter && !sleep_reset) |=> pd_exit_cmd ##1 !pd_exit_cmd;
  endproperty
  a_pdx_cmd: assert property (p_pdx_cmd)
    else $error("power-down-exit command missing or not one cycle");

  property p_cke_blocks;
    !sdram_cke_level |-> !auto_cmd_enable;
  endproperty
  a_cke_blocks: assert property (p_cke_blocks)
    else $error("automatic commands allowed with cke bit clear");

  property p_run_blocks;
    (!sdram_clk1_run || !sdram_clk2_run) |-> !auto_cmd_enable;
  endproperty
  a_run_blocks: assert property (p_run_blocks)
    else $error("automatic commands allowed with a clock stopped");

  property p_sleep_run;
    sleep_enter |=> !sdram_clk1_run && !sdram_clk2_run ##1 !mem_clock_pin[1] && !mem_clock_pin[2];
  endproperty
  a_sleep_run: assert property (p_sleep_run)
    else $error("clock run bits or pins not stopped after sleep");

  property p_cke_apd;
    cke_auto_power_down && !sdram01_busy && !sdram23_busy |-> !mem_clock_enable_pin[1];
  endproperty
  a_cke_apd: assert property (p_cke_apd)
    else $error("cke pin 1 high while SDRAM banks idle under auto power-down");

  property p_srf_reset;
    sleep_reset |=> self_refresh_ctrl && sdram_clk1_half_rate && sdram_clk2_half_rate;
  endproperty
  a_srf_reset: assert property (p_srf_reset)
    else $error("sleep reset did not restore self-refresh and divide bits");
endmodule
`default_nettype wire

// file: testbench/scp_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// Memory side of the pins: counts clock edges and commands seen
module scp_mem_model
  import scp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [2:0] mem_clock_pin,
  input  wire logic       power_down_cmd,
  input  wire logic       pd_exit_cmd,
  output int              edge0,
  output int              edge1,
  output int              edge2,
  output int              n_pd,
  output int              n_exit,
  output logic            powered_down
);
  // Rising edges per memory clock pin (ROM pin 0 and both SDRAM pins), so the bench can judge the rate
  initial begin
    edge0 = 0;
    edge1 = 0;
    edge2 = 0;
    n_pd = 0;
    n_exit = 0;
    powered_down = 1'b0;
  end
  always @(posedge mem_clock_pin[0]) begin
    edge0 = edge0 + 1;
  end
  always @(posedge mem_clock_pin[1]) begin
    edge1 = edge1 + 1;
  end
  always @(posedge mem_clock_pin[2]) begin
    edge2 = edge2 + 1;
  end
  // Command strobes are one cycle wide, so sample them on the system clock
  always @(posedge clk_sys) begin
    if (power_down_cmd === 1'b1) begin
      n_pd = n_pd + 1;
      powered_down = 1'b1;
    end
    if (pd_exit_cmd === 1'b1) begin
      n_exit = n_exit + 1;
      powered_down = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/scp_clk_power_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module scp_clk_power_ctrl_tb_top;
  import scp_pkg::*;
  logic        clk_sys, rst, cyc, stb, we, slp_in, slp_rst, rom_busy, b01, b23, strap;
  logic [7:0]  adr;      // Bus address
  logic [31:0] dat;      // Bus write data
  logic [31:0] rd;       // Last read word
  logic [31:0] wb_dat_o; // Slave read data
  logic        wb_ack_o, pd_cmd, exit_cmd, auto_en, pdn;
  logic [2:0]  clk_pins; // Memory clock pins
  logic [1:0]  cke_pins; // Clock-enable pins
  logic [3:0]  sel;      // Bus byte lanes
  logic [3:0]  lanes;    // Lanes for the next request
  int          e0, e1, e2, npd, nex, s0, s1, s2, n_fail, checks;
  scp_clk_power_ctrl dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sleep_enter(slp_in), .sleep_reset(slp_rst),
    .rom_bank_busy(rom_busy), .sdram01_busy(b01), .sdram23_busy(b23),
    .boot_sync_rom_select(strap), .mem_clock_pin(clk_pins),
    .mem_clock_enable_pin(cke_pins), .power_down_cmd(pd_cmd), .pd_exit_cmd(exit_cmd),
    .auto_cmd_enable(auto_en));
  scp_mem_model mem (.clk_sys(clk_sys), .mem_clock_pin(clk_pins), .power_down_cmd(pd_cmd),
    .pd_exit_cmd(exit_cmd), .edge0(e0), .edge1(e1), .edge2(e2), .n_pd(npd), .n_exit(nex),
    .powered_down(pdn));
  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Counts, verdict and the single end of the run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Compare one value, report a mismatch at once
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic single Wishbone cycle; waits for ack under a bounded count
  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= lanes;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      $display("unexpected timeout on bus ack");
      finish_test();
    end
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Read a word and compare it
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb_xfer(a, 1'b0, 32'h0000_0000);
    chk(what, exp, rd);
  endtask
  // Write, then let the command cycle pass before the counts are judged
  task automatic wr(input logic [31:0] d);
    wb_xfer(8'h1c, 1'b1, d);
    repeat (3) @(posedge clk_sys);
  endtask
  // Rising edges on the ROM pin and both SDRAM clock pins over a fixed span of cycles
  task automatic rate(input int cyc_n);
    s0 = e0;
    s1 = e1;
    s2 = e2;
    repeat (cyc_n) @(posedge clk_sys);
    s0 = e0 - s0;
    s1 = e1 - s1;
    s2 = e2 - s2;
  endtask
  initial begin
    {cyc, stb, we, slp_in, slp_rst, rom_busy, b01, b23} = '0;
    adr = 8'h00;
    dat = 32'h0000_0000;
    strap = 1'b1;
    sel = 4'hf;
    lanes = 4'hf;
    rst = 1'b1;
    n_fail = 0;
    checks = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    // Reset image, strap loaded into the ROM bits, reserved writes ignored
    rd_chk(8'h1c, 32'h8443_0000, "reset image");
    chk("cke pins", 32'h1, {30'h0, cke_pins});
    rate(20);
    chk("stopped pins", 32'h0, s1 + s2);
    chk("rom pin half rate", 32'h1, {31'h0, s0 >= 4 && s0 <= 6});
    wr(32'hcdc3_0000);
    rd_chk(8'h1c, 32'h8443_0000, "reserved bits");
    wb_xfer(8'h20, 1'b1, 32'hffff_ffff);
    rd_chk(8'h20, 32'h0000_0000, "unmapped read");
    rd_chk(8'h1c, 32'h8443_0000, "after unmapped write");
    // Lane 2 alone: byte 3 fields keep their values
    lanes = 4'h4;
    wr(32'h0000_0000);
    lanes = 4'hf;
    rd_chk(8'h1c, 32'h8400_0000, "lane 2 write");
    wr(32'h8443_0000);
    $display("test reset and map done");
    // Self-refresh set: raising cke with both clocks running gives no command
    wr(32'h8663_0000);
    wr(32'h8673_0000);
    chk("exit refused", 32'h0, nex);
    wr(32'h0673_0000);
    wr(32'h0663_0000);
    chk("power down", 32'h1, npd);
    chk("auto off cke", 32'h0, {31'h0, auto_en});
    wr(32'h0673_0000);
    chk("pd exit", 32'h1, nex);
    chk("model state", 32'h0, {31'h0, pdn});
    wr(32'h0273_0000);
    chk("auto on", 32'h1, {31'h0, auto_en});
    $display("test commands done");
    // Pin 1 half rate, pin 2 full rate
    rate(40);
    chk("half rate ok", 32'h1, {31'h0, s1 >= 9 && s1 <= 11});
    chk("full rate ok", 32'h1, {31'h0, s2 >= 19 && s2 <= 21});
    wr(32'h0073_0000);
    chk("auto run2 off", 32'h0, {31'h0, auto_en});
    rate(20);
    chk("pin2 stopped", 32'h0, s2);
    wr(32'h0053_0000);
    wr(32'h0043_0000);
    chk("no clocks no cmd", 32'h1, npd);
    $display("test rates done");
    // Auto power-down, both bits written alike after setup
    wr(32'h3073_0000);
    chk("no clocks no exit", 32'h1, nex);
    chk("idle sdram cke", 32'h0, {31'h0, cke_pins[1]});
    chk("idle rom cke", 32'h0, {31'h0, cke_pins[0]});
    rate(20);
    chk("idle pin1 stops", 32'h0, s1);
    chk("idle rom pin stops", 32'h0, s0);
    b01 <= 1'b1;
    rom_busy <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("busy cke", 32'h3, {30'h0, cke_pins});
    rate(20);
    chk("busy pin1 runs", 32'h1, {31'h0, s1 > 0});
    chk("busy rom pin runs", 32'h1, {31'h0, s0 > 0});
    b01 <= 1'b0;
    rom_busy <= 1'b0;
    $display("test auto power-down done");
    // Sleep entry clears cke and run bits, sleep reset reloads the strap
    @(posedge clk_sys);
    slp_in <= 1'b1;
    @(posedge clk_sys);
    slp_in <= 1'b0;
    rd_chk(8'h1c, 32'h3043_0000, "sleep entry");
    strap <= 1'b0;
    repeat (5) @(posedge clk_sys);
    slp_rst <= 1'b1;
    @(posedge clk_sys);
    slp_rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rd_chk(8'h1c, 32'h8440_0000, "sleep reset");
    $display("test sleep done");
    finish_test();
  end
endmodule
`default_nettype wire
